// *** aba_ctl.sv ***
// converter control, host byte bus and apb register slave
//
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps

// Summary of operation
// - internal mode: write edge latches byte, acquires, converts
// - external mode: first write acquires, second converts
// - read strobe with select low drives result
// - upper select high gives top four bits
// - line n carries bit n, or bit n+8 for n up to 3
// - shutdown pin low forces full power-down
// - interrupt released soon after read strobe falls
// - interrupt on done, cleared by read or write
// - control byte layout; internal mode acquisition lasts six ticks
// - upper byte pads zeros or sign bit
// - write during conversion restarts acquisition
module aba_ctl #(
    parameter int unsigned INT_DIV    = aba_pkg::INT_CLK_DIV,
    parameter int unsigned ACQ_CYCLES = aba_pkg::ACQ_TICKS
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              cs_n,
    input  wire logic              wr_n,
    input  wire logic              rd_n,
    input  wire logic              upper_byte_select,
    input  wire logic              powerdown_force_n,
    input  wire logic [7:0]        data_in,
    output logic      [7:0]        data_out,
    output logic                   data_oe,
    input  wire logic              conv_clk_in,
    input  wire logic              comp_hi,
    output logic                   int_n,
    output logic                   irq,
    output logic                   track,
    output logic      [11:0]       sar_code,
    output aba_pkg::aba_ctrl_t     ctrl_out,
    output logic                   full_powerdown_state,
    output logic                   standby_powerdown_state
);

    // refuse settings the counters cannot serve
    if (INT_DIV < 2 || INT_DIV > 255) begin : g_div_chk
        $error("aba_ctl: INT_DIV must be 2..255");
    end
    if (ACQ_CYCLES < 1 || ACQ_CYCLES > 7) begin : g_acq_chk
        $error("aba_ctl: ACQ_CYCLES must be 1..7");
    end

    localparam logic [7:0] DIV_LAST = 8'(INT_DIV - 1);
    localparam logic [2:0] ACQ_LAST = 3'(ACQ_CYCLES - 1);
    localparam logic [3:0] BIT_TOP  = 4'(aba_pkg::CONV_TICKS - 1);

    aba_pkg::aba_pins_t   pins_s;
    aba_pkg::aba_ctrl_t   ctrl_q;
    aba_pkg::aba_state_t  state_q;
    aba_pkg::aba_state_t  state_d;

    logic                 wr_prev_q;
    logic                 rd_prev_q;
    logic                 clk_prev_q;
    logic                 ext_clk_q;
    logic [7:0]           div_q;
    logic [2:0]           acq_cnt_q;
    logic [3:0]           bit_q;
    logic [11:0]          code_q;
    logic [11:0]          result_q;
    logic [aba_pkg::EV_W-1:0] irq_stat_q;
    logic [aba_pkg::EV_W-1:0] irq_en_q;

    // all host pins cross into pclk through two flops
    aba_sync #(
        .W       (15),
        .RST_VAL (aba_pkg::PINS_RST)
    ) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({cs_n, wr_n, rd_n, upper_byte_select, powerdown_force_n,
                    conv_clk_in, comp_hi, data_in}),
        .sync_out (pins_s)
    );

    // host strobe decoding
    wire logic forced_w   = !pins_s.powerdown_force_n;
    wire logic wr_rise_w  = !wr_prev_q && pins_s.wr_n && !pins_s.cs_n;
    wire logic rd_fall_w  = rd_prev_q && !pins_s.rd_n && !pins_s.cs_n;
    wire logic rd_act_w   = !pins_s.cs_n && !pins_s.rd_n;
    wire aba_pkg::aba_ctrl_t new_ctrl_w = pins_s.data;
    wire logic [1:0] new_pd_w = {new_ctrl_w.power_clock_mode_hi,
                                 new_ctrl_w.power_clock_mode_lo};
    wire logic [1:0] pd_w     = {ctrl_q.power_clock_mode_hi, ctrl_q.power_clock_mode_lo};

    // conversion clock: divided pclk or edges of the clock pin
    wire logic int_tick_w = (div_q == DIV_LAST);
    wire logic ext_tick_w = !clk_prev_q && pins_s.conv_clk;
    wire logic tick_w     = ext_clk_q ? ext_tick_w : int_tick_w;

    // sar step: keep or drop trial bit, then try the next lower one
    wire logic last_bit_w = (bit_q == 4'h0);
    logic [11:0] code_step_w;
    always_comb begin
        code_step_w = code_q;
        if (!pins_s.comp_hi) begin
            code_step_w[bit_q] = 1'b0;
        end
        if (!last_bit_w) begin
            code_step_w[bit_q - 4'h1] = 1'b1;
        end
    end

    // a write wins over a conversion step in the same cycle, but not over the last acquisition tick
    wire logic acq_end_w = (state_q == aba_pkg::ST_ACQ_INT) && tick_w
                           && (acq_cnt_q == ACQ_LAST);
    wire logic conv_step_w = (state_q == aba_pkg::ST_CONV) && tick_w && !wr_rise_w;
    wire logic done_w    = conv_step_w && last_bit_w && !forced_w;
    wire logic abort_w   = wr_rise_w && (state_q == aba_pkg::ST_CONV);
    wire logic start_conv_w = acq_end_w ||
                              (wr_rise_w && state_q == aba_pkg::ST_ACQ_EXT
                               && !new_ctrl_w.acquisition_timing_select);

    // sequencing of acquisition and conversion
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            aba_pkg::ST_IDLE: begin
                state_d = aba_pkg::ST_IDLE;
            end
            aba_pkg::ST_ACQ_INT: begin
                if (acq_end_w) begin
                    state_d = aba_pkg::ST_CONV;
                end
            end
            aba_pkg::ST_ACQ_EXT: begin
                state_d = aba_pkg::ST_ACQ_EXT;
            end
            aba_pkg::ST_CONV: begin
                if (conv_step_w && last_bit_w) begin
                    state_d = aba_pkg::ST_IDLE;
                end
            end
        endcase
        if (wr_rise_w) begin
            if (start_conv_w) begin
                state_d = aba_pkg::ST_CONV;
            end else if (new_ctrl_w.acquisition_timing_select) begin
                state_d = aba_pkg::ST_ACQ_EXT;
            end else begin
                state_d = aba_pkg::ST_ACQ_INT;
            end
        end
        if (forced_w) begin
            state_d = aba_pkg::ST_IDLE;
        end
    end

    // state and strobe history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q    <= aba_pkg::ST_IDLE;
            wr_prev_q  <= 1'b1;
            rd_prev_q  <= 1'b1;
            clk_prev_q <= 1'b0;
        end else begin
            state_q    <= state_d;
            wr_prev_q  <= pins_s.wr_n;
            rd_prev_q  <= pins_s.rd_n;
            clk_prev_q <= pins_s.conv_clk;
        end
    end

    // control byte capture; power-down codes leave the clock mode alone
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q    <= aba_pkg::CTRL_RST;
            ext_clk_q <= 1'b1;
        end else if (wr_rise_w) begin
            ctrl_q    <= new_ctrl_w;
            if (new_pd_w == aba_pkg::PD_EXT_CLK) begin
                ext_clk_q <= 1'b1;
            end else if (new_pd_w == aba_pkg::PD_INT_CLK) begin
                ext_clk_q <= 1'b0;
            end
        end
    end

    // oscillator divider runs free; a write does not realign its phase, so the first acquisition tick can come early
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= 8'h00;
        end else if (int_tick_w) begin
            div_q <= 8'h00;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end

    // acquisition tick counter, restarted by every accepted write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acq_cnt_q <= 3'h0;
        end else if (wr_rise_w) begin
            acq_cnt_q <= 3'h0;
        end else if (state_q == aba_pkg::ST_ACQ_INT && tick_w) begin
            acq_cnt_q <= acq_cnt_q + 3'h1;
        end
    end

    // sar and result latch; trial code preset at every write with the shutdown pin high so the synced
    // comparator has settled before a host-timed conversion's first tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            code_q   <= aba_pkg::SAR_START;
            bit_q    <= BIT_TOP;
            result_q <= aba_pkg::RESULT_RST;
        end else if ((start_conv_w || wr_rise_w) && !forced_w) begin
            code_q   <= aba_pkg::SAR_START;
            bit_q    <= BIT_TOP;
        end else if (conv_step_w) begin
            code_q   <= code_step_w;
            bit_q    <= last_bit_w ? BIT_TOP : bit_q - 4'h1;
            if (last_bit_w) begin
                result_q <= code_step_w;
            end
        end
    end

    // completion interrupt pin: set wins over read or write release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_n <= 1'b1;
        end else if (done_w) begin
            int_n <= 1'b0;
        end else if (rd_fall_w || wr_rise_w) begin
            int_n <= 1'b1;
        end
    end

    // byte lanes of the result; upper lanes pad zero or sign
    wire logic pad_w = ctrl_q.polarity_select & result_q[11];
    wire logic [7:0] hi_byte_w = {{4{pad_w}}, result_q[11:8]};
    wire logic [7:0] lo_byte_w = result_q[7:0];

    // bus drive, registered so the pins come straight from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_oe  <= 1'b0;
            data_out <= 8'h00;
        end else begin
            data_oe  <= rd_act_w;
            data_out <= pins_s.upper_byte_select ? hi_byte_w : lo_byte_w;
        end
    end

    // analog-side controls and power state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            track                   <= 1'b0;
            sar_code                <= aba_pkg::SAR_START;
            ctrl_out                <= aba_pkg::CTRL_RST;
            full_powerdown_state    <= 1'b0;
            standby_powerdown_state <= 1'b0;
        end else begin
            track    <= (state_q == aba_pkg::ST_ACQ_INT) || (state_q == aba_pkg::ST_ACQ_EXT);
            sar_code <= code_q;
            ctrl_out <= ctrl_q;
            full_powerdown_state    <= forced_w ||
                                       (state_q == aba_pkg::ST_IDLE && pd_w == aba_pkg::PD_FULL);
            standby_powerdown_state <= !forced_w && state_q == aba_pkg::ST_IDLE
                                       && pd_w == aba_pkg::PD_STANDBY;
        end
    end

    // apb decode: answer in the second access cycle
    wire logic apb_acc_w   = psel && penable && !pready;
    wire logic hit_w       = (paddr == aba_pkg::ADDR_CTRL) || (paddr == aba_pkg::ADDR_STATUS)
                             || (paddr == aba_pkg::ADDR_RESULT)
                             || (paddr == aba_pkg::ADDR_IRQ_STAT)
                             || (paddr == aba_pkg::ADDR_IRQ_CLR)
                             || (paddr == aba_pkg::ADDR_IRQ_EN);
    wire logic apb_wr_w    = psel && penable && pready && pwrite && hit_w;
    wire logic clr_wr_w    = apb_wr_w && (paddr == aba_pkg::ADDR_IRQ_CLR);
    wire logic en_wr_w     = apb_wr_w && (paddr == aba_pkg::ADDR_IRQ_EN);
    wire logic [aba_pkg::EV_W-1:0] ev_w = {wr_rise_w, abort_w, done_w};
    wire logic [31:0] status_w = {24'h00_0000, int_n, forced_w, ext_clk_q,
                                  full_powerdown_state, standby_powerdown_state,
                                  1'b0, state_q};

    logic [31:0] rd_mux_w;
    always_comb begin
        rd_mux_w = 32'h0000_0000;
        unique case (paddr)
            aba_pkg::ADDR_CTRL:     rd_mux_w = {24'h00_0000, ctrl_q};
            aba_pkg::ADDR_STATUS:   rd_mux_w = status_w;
            aba_pkg::ADDR_RESULT:   rd_mux_w = {20'h0_0000, result_q};
            aba_pkg::ADDR_IRQ_STAT: rd_mux_w = {29'h0000_0000, irq_stat_q};
            aba_pkg::ADDR_IRQ_EN:   rd_mux_w = {29'h0000_0000, irq_en_q};
            default:                rd_mux_w = 32'h0000_0000;
        endcase
    end

    // apb handshake and read data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= apb_acc_w;
            pslverr <= apb_acc_w && !hit_w;
            prdata  <= (apb_acc_w && !pwrite) ? rd_mux_w : 32'h0000_0000;
        end
    end

    // sticky events, mask and interrupt line; a new event beats the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_q <= '0;
            irq_en_q   <= aba_pkg::IRQ_EN_RST;
            irq        <= 1'b0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~(clr_wr_w ? pwdata[aba_pkg::EV_W-1:0] : '0)) | ev_w;
            if (en_wr_w) begin
                irq_en_q <= pwdata[aba_pkg::EV_W-1:0];
            end
            irq        <= |(irq_stat_q & irq_en_q);
        end
    end

endmodule

// *** aba_pkg.sv ***
// constants, types and register map of the acquisition control block
package aba_pkg;

    // converter clocks in kHz, timing in conversion clock ticks
    localparam int unsigned CLK_KHZ       = 20000;
    localparam int unsigned INT_OSC_KHZ   = 1560;
    localparam int unsigned INT_CLK_DIV   = CLK_KHZ / INT_OSC_KHZ;
    localparam int unsigned ACQ_TICKS     = 6;
    localparam int unsigned CONV_TICKS    = 12;
    localparam int unsigned RES_W         = 12;

    // apb register byte addresses
    localparam logic [7:0] ADDR_CTRL      = 8'h00;
    localparam logic [7:0] ADDR_STATUS    = 8'h04;
    localparam logic [7:0] ADDR_RESULT    = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STAT  = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_CLR   = 8'h10;
    localparam logic [7:0] ADDR_IRQ_EN    = 8'h14;

    // event bit positions in status, clear and enable registers
    localparam int unsigned EV_DONE       = 0;
    localparam int unsigned EV_ABORT      = 1;
    localparam int unsigned EV_WRITE      = 2;
    localparam int unsigned EV_W          = 3;

    // reset values
    localparam logic [7:0]       CTRL_RST    = 8'h00;
    localparam logic [EV_W-1:0]  IRQ_EN_RST  = 3'h0;
    localparam logic [11:0]      SAR_START   = 12'h800;
    localparam logic [11:0]      RESULT_RST  = 12'h000;

    // power and clock mode codes of the control byte
    localparam logic [1:0] PD_EXT_CLK     = 2'h0;
    localparam logic [1:0] PD_INT_CLK     = 2'h1;
    localparam logic [1:0] PD_STANDBY     = 2'h2;
    localparam logic [1:0] PD_FULL        = 2'h3;

    // control byte layout, msb first
    typedef struct packed {
        logic       power_clock_mode_hi;
        logic       power_clock_mode_lo;
        logic       acquisition_timing_select;
        logic       range_magnitude_select;
        logic       polarity_select;
        logic       channel_sel_2;
        logic       channel_sel_1;
        logic       channel_sel_0;
    } aba_ctrl_t;

    // host pins after the synchroniser
    typedef struct packed {
        logic       cs_n;
        logic       wr_n;
        logic       rd_n;
        logic       upper_byte_select;
        logic       powerdown_force_n;
        logic       conv_clk;
        logic       comp_hi;
        logic [7:0] data;
    } aba_pins_t;

    localparam logic [14:0] PINS_RST      = 15'h7400;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ACQ_INT,
        ST_ACQ_EXT,
        ST_CONV
    } aba_state_t;

endpackage

// *** aba_sync.sv ***
// two flip-flop synchroniser for a group of asynchronous pins
`timescale 1ns/100ps
module aba_sync #(
    parameter int unsigned W       = 16,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_q;

    // first stage is read only by the second stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q   <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

// *** aba_ctl_assertions.sv ***
// port-level assertions for the acquisition control block
`timescale 1ns/100ps
module aba_ctl_chk #(
    parameter int unsigned INT_DIV    = 12,
    parameter int unsigned ACQ_CYCLES = 6
) (
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pready,
    input wire logic               cs_n,
    input wire logic               wr_n,
    input wire logic               rd_n,
    input wire logic               upper_byte_select,
    input wire logic               powerdown_force_n,
    input wire logic [7:0]         data_out,
    input wire logic               data_oe,
    input wire logic               int_n,
    input wire logic               track,
    input wire aba_pkg::aba_ctrl_t ctrl_out,
    input wire logic               full_powerdown_state
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // tick divider free-runs, so the first tick may come up to one divide early
    localparam int unsigned TRK_LO = (ACQ_CYCLES - 1) * INT_DIV;
    localparam int unsigned TRK_HI = ACQ_CYCLES * INT_DIV + 2;
    logic [15:0] trk_q;
    logic        ext_q;
    // length of the current acquisition and whether the host timed it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trk_q <= 16'h0000;
            ext_q <= 1'b0;
        end else begin
            trk_q <= track ? trk_q + 16'h0001 : 16'h0000;
            ext_q <= track & (ext_q | ctrl_out.acquisition_timing_select);
        end
    end
    chk_bus_gate: assert property (data_oe |-> $past(!cs_n && !rd_n, 3))
        else $error("data bus driven without select and read strobe");
    chk_pad_zero: assert property (data_oe && $past(upper_byte_select, 3)
        && !ctrl_out.polarity_select |-> data_out[7:4] == 4'h0)
        else $error("upper byte pad not zero in unipolar mode");
    chk_pad_sign: assert property (data_oe && $past(upper_byte_select, 3)
        && ctrl_out.polarity_select |-> data_out[7:4] == {4{data_out[3]}})
        else $error("upper byte pad not sign in bipolar mode");
    chk_int_release: assert property (!int_n && !cs_n && $fell(rd_n) |-> ##[1:4] int_n)
        else $error("interrupt not released after read strobe");
    chk_int_quiet: assert property ($fell(int_n) |-> !track && $stable(ctrl_out))
        else $error("interrupt raised outside a finished conversion");
    chk_pd_force: assert property ((!powerdown_force_n)[*6]
        |-> full_powerdown_state && !track)
        else $error("shutdown pin did not force power-down");
    chk_acq_len: assert property ($fell(track) && !ext_q && !ctrl_out.power_clock_mode_hi
        && ctrl_out.power_clock_mode_lo |-> trk_q >= TRK_LO && trk_q <= TRK_HI)
        else $error("internal acquisition length wrong");
    chk_write_start: assert property ($rose(wr_n) && !cs_n && powerdown_force_n
        && !ctrl_out.acquisition_timing_select |-> ##[1:6] track)
        else $error("write did not start acquisition");
    chk_apb_wait: assert property (psel && penable && !pready |=> pready)
        else $error("apb answer late");
endmodule

bind aba_ctl aba_ctl_chk #(.INT_DIV(INT_DIV), .ACQ_CYCLES(ACQ_CYCLES)) u_aba_ctl_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
    .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .upper_byte_select(upper_byte_select),
    .powerdown_force_n(powerdown_force_n), .data_out(data_out), .data_oe(data_oe),
    .int_n(int_n), .track(track), .ctrl_out(ctrl_out),
    .full_powerdown_state(full_powerdown_state));

// *** aba_host_model.sv ***
// host processor model on the converter byte bus
`timescale 1ns/100ps
module aba_host_model (
    input  wire logic  pclk,
    output logic       cs_n,
    output logic       wr_n,
    output logic       rd_n,
    output logic       upper_byte_select,
    output logic [7:0] host_data,
    output logic       host_oe
);
    logic [7:0] wbyte_q = 8'h00;
    logic [7:0] noise_q = 8'h5a;
    // released lines wander, so a stale byte is never mistaken for a drive
    assign host_data = host_oe ? wbyte_q : noise_q;
    always @(posedge pclk) noise_q <= ~noise_q + 8'h01;
    initial begin
        cs_n = 1'b1;
        wr_n = 1'b1;
        rd_n = 1'b1;
        upper_byte_select = 1'b0;
        host_oe = 1'b0;
    end
    // control byte write; data held well past the rising strobe
    task automatic write_byte(input logic [7:0] b);
        @(posedge pclk);
        cs_n    <= 1'b0;
        wr_n    <= 1'b0;
        host_oe <= 1'b1;
        wbyte_q <= b;
        repeat (5) @(posedge pclk);
        wr_n    <= 1'b1;
        repeat (5) @(posedge pclk);
        cs_n    <= 1'b1;
        host_oe <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask
    // one result byte read
    task automatic read_byte(input logic hi);
        @(posedge pclk);
        upper_byte_select <= hi;
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        repeat (6) @(posedge pclk);
        rd_n <= 1'b1;
        cs_n <= 1'b1;
        repeat (4) @(posedge pclk);
    endtask
endmodule

// *** aba_ctl_tb.sv ***
// self-checking bench: apb master, host model, comparator stand-in
`timescale 1ns/100ps
module aba_ctl_tb;
    logic               pclk = 1'b0;
    logic               presetn = 1'b0;
    logic               psel = 1'b0;
    logic               penable = 1'b0;
    logic               pwrite = 1'b0;
    logic [7:0]         paddr = 8'h00;
    logic [31:0]        pwdata = 32'h0000_0000;
    logic               powerdown_force_n = 1'b1;
    logic [11:0]        vin = 12'h000;
    logic [3:0]         cdiv = 4'h0;
    logic [1:0]         oe_d = 2'b00;
    logic [31:0]        prdata;
    logic               pready, pslverr, data_oe, int_n, irq, track, full_pd, stby_pd;
    logic               cs_n, wr_n, rd_n, upper_byte_select, host_oe;
    logic [7:0]         host_data, data_out, b;
    logic [11:0]        sar_code;
    aba_pkg::aba_ctrl_t ctrl_out;
    int                 seed = 69;
    int                 n_mismatch = 0;
    int                 check_count = 0;
    logic [31:0]        exp_apb[$];
    logic [7:0]         exp_bus[$];
    // shared data lines, an ideal comparator and a 2 MHz converter clock
    wire  [7:0]         data_in = (data_oe === 1'b1) ? data_out : host_data;
    wire                comp_hi = vin >= sar_code;
    wire                conv_clk_in = cdiv < 4'h5;
    always #25 pclk = ~pclk;
    always @(posedge pclk) cdiv <= (cdiv == 4'h9) ? 4'h0 : cdiv + 4'h1;
    aba_ctl u_aba_ctl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
        .upper_byte_select(upper_byte_select), .powerdown_force_n(powerdown_force_n),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .conv_clk_in(conv_clk_in),
        .comp_hi(comp_hi), .int_n(int_n), .irq(irq), .track(track), .sar_code(sar_code),
        .ctrl_out(ctrl_out), .full_powerdown_state(full_pd), .standby_powerdown_state(stby_pd));
    aba_host_model u_aba_host_model (.pclk(pclk), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
        .upper_byte_select(upper_byte_select), .host_data(host_data), .host_oe(host_oe));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // watcher: second cycle of a bus drive, or an apb read answer, meets the oldest note
    always @(posedge pclk) begin
        oe_d <= {oe_d[0], data_oe};
        if (data_oe && oe_d == 2'b01) check("bus byte", 32'(data_out), 32'(exp_bus.pop_front()));
        if (psel && pready && !pwrite) check("apb word", prdata, exp_apb.pop_front());
    end
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic err);
        int k;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 20 && pready !== 1'b1; k++) @(posedge pclk);
        check("apb answer", 32'({pready, pslverr}), 32'({1'b1, err}));
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic apb_rd(input logic [7:0] a, input logic [31:0] e);
        exp_apb.push_back(e);
        apb(a, 1'b0, 32'h0000_0000, 1'b0);
    endtask
    // write a byte, await completion, read both halves of the result
    task automatic convert(input logic [7:0] c);
        int k;
        u_aba_host_model.write_byte(c);
        for (k = 0; k < 4000 && int_n !== 1'b0; k++) @(posedge pclk);
        check("int_n low", 32'(int_n), 32'h0000_0000);
        exp_bus.push_back(vin[7:0]);
        u_aba_host_model.read_byte(1'b0);
        check("int_n after read", 32'(int_n), 32'h0000_0001);
        exp_bus.push_back({c[3] ? {4{vin[11]}} : 4'h0, vin[11:8]});
        u_aba_host_model.read_byte(1'b1);
    endtask
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        check("int_n idle", 32'(int_n), 32'h0000_0001);
        apb(aba_pkg::ADDR_IRQ_EN, 1'b1, 32'h0000_0007, 1'b0);
        apb_rd(aba_pkg::ADDR_IRQ_EN, 32'h0000_0007);
        apb(8'h18, 1'b1, 32'h0000_0000, 1'b1);
        // every power and clock mode, both polarities
        for (int i = 0; i < 4; i++) begin
            vin <= 12'($random(seed));
            b = {i[1:0], 1'b0, i[0], i[1] ^ i[0], i[2:0]};
            convert(b);
            check("control byte", 32'(ctrl_out), 32'(b));
            check("power states", 32'({full_pd, stby_pd}), 32'({i == 3, i == 2}));
            apb_rd(aba_pkg::ADDR_RESULT, 32'(vin));
            apb_rd(aba_pkg::ADDR_IRQ_STAT, 32'h0000_0005);
            check("irq", 32'(irq), 32'h0000_0001);
            apb(aba_pkg::ADDR_IRQ_CLR, 1'b1, 32'h0000_0007, 1'b0);
        end
        $display("mode sweep done");
        vin <= 12'($random(seed));
        u_aba_host_model.write_byte(8'h60);
        repeat (300) @(posedge pclk);
        check("held acquisition", 32'({track, int_n}), 32'h0000_0003);
        convert(8'h40);
        apb(aba_pkg::ADDR_IRQ_CLR, 1'b1, 32'h0000_0007, 1'b0);
        $display("host-timed done");
        u_aba_host_model.write_byte(8'h40);
        repeat (100) @(posedge pclk);
        check("mid conversion", 32'({track, int_n}), 32'h0000_0001);
        vin <= 12'($random(seed));
        convert(8'h40);
        apb_rd(aba_pkg::ADDR_IRQ_STAT, 32'h0000_0007);
        apb(aba_pkg::ADDR_IRQ_EN, 1'b1, 32'h0000_0000, 1'b0);
        repeat (2) @(posedge pclk);
        check("irq masked", 32'(irq), 32'h0000_0000);
        apb(aba_pkg::ADDR_IRQ_CLR, 1'b1, 32'h0000_0007, 1'b0);
        apb_rd(aba_pkg::ADDR_IRQ_STAT, 32'h0000_0000);
        $display("abort and interrupt done");
        powerdown_force_n <= 1'b0;
        u_aba_host_model.write_byte(8'h41);
        repeat (300) @(posedge pclk);
        check("forced down", 32'({full_pd, track, int_n}), 32'h0000_0005);
        apb_rd(aba_pkg::ADDR_STATUS, 32'h0000_00d0);
        powerdown_force_n <= 1'b1;
        repeat (100) @(posedge pclk);
        convert(8'h41);
        $display("shutdown done");
        test_done();
    end
    initial begin
        repeat (30000) @(posedge pclk);
        n_mismatch++;
        test_done();
    end
endmodule
